// file: csyn_serial_port.sv
// serial programming port and control register of the dual clock
// synthesizer: preamble unlock, pair-coded bits, load, watchdog
// assumes pins arrive asynchronously; register contents other than
// the control register are taken from the load strobe by outside logic
// pins must hold each level three core clocks
// mem_vco_tick pulses at the memory oscillator rate
//
// Function
// - power-down mode bit picks mode one or two
// - fallback bit picks reference or memory clock
// - timeout from memory oscillator, doubled when set
// - duty trim clear shortens output high time
// - per-register prescale: clear two, set four
// - select pins double as serial clock, data
// - no serial programming during power-down
// - five high rising edges then one low
// - every pin transition restarts the watchdog
// - watchdog expiry relocks and discards shifted data
// - selects reach decoder only after watchdog expiry
// - bit is complement on fall, true on rise
// - frame: start, 21 data, 3 address, stop
// - stop without exactly 24 bits is error
// - valid stop loads addressed register, then relocks
// - extra bits past full register give error
// - fallback clock drives video while oscillator settles
`timescale 1ns/1ps
`include "csyn_defines.svh"

module csyn_serial_port #(
    parameter logic [`CSYN_TMR_W-1:0] WDOG_CYCLES =
        `CSYN_TMR_W'(`CSYN_WDOG_CYCLES),
    parameter logic [`CSYN_TMR_W-1:0] SETTLE_CYCLES =
        `CSYN_TMR_W'(`CSYN_SETTLE_CYCLES)
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic select_low_serial_clock,
    input wire logic select_high_serial_data,
    input wire logic powerdown_pin_n,
    input wire logic mem_vco_tick,
    output logic [`CSYN_CTL_W-1:0] synth_control,
    output logic [1:0] video_sel,
    output logic load_strobe,
    output logic [`CSYN_ADDR_W-1:0] load_addr,
    output logic [`CSYN_DATA_W-1:0] load_data,
    output logic serial_error,
    output logic serial_unlocked,
    output logic video_fallback_active,
    output logic video_fallback_from_mem,
    output logic powerdown_mode1,
    output logic powerdown_mode2,
    output logic duty_shorten_en,
    output logic [2:0] prescale_by4
);

    // ****************************************************************
    // reset image of the state
    // ****************************************************************

    // reserved bit five comes up set; hosts clear it
    // on their first control write
    localparam csyn_pkg::csyn_top_st_t ST_RST = '{
        state: csyn_pkg::CSYN_LOCKED,
        pre_cnt: 3'h0,
        shreg: 24'h000000,
        bit_cnt: 5'h00,
        fall_bit: 1'b0,
        clk_d: 1'b0,
        dat_d: 1'b0,
        ctl: `CSYN_CTL_RESET,
        sel_dec: 2'h0,
        ld_stb: 1'b0,
        ld_addr: 3'h0,
        ld_data: 21'h000000,
        err_stb: 1'b0
    };

    // ****************************************************************
    // declarations
    // ****************************************************************

    csyn_pkg::csyn_top_st_t st_r; // whole registered state
    csyn_pkg::csyn_top_st_t st_nxt; // next state
    logic sclk_s; // synchronised serial clock / low select
    logic sdat_s; // synchronised serial data / high select
    logic pd_n_s; // synchronised power-down pin, low active
    logic pd_active; // device held in power-down
    logic sclk_rise; // rising edge of serial clock
    logic sclk_fall; // falling edge of serial clock
    logic pin_change; // any transition on either pin
    logic wdog_expired; // one-cycle pulse at watchdog expiry
    logic new_selection; // pins differ from decoded selection
    logic settle_restart; // start oscillator settle interval
    logic settling; // settle interval running

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************

    // two flops per pin keep metastability out;
    // the slow link easily affords the delay
    // serial clock shares the low select pin
    csyn_sync2 u_sync_clk (
        .clk(clk),
        .arst_n(arst_n),
        .pin_in(select_low_serial_clock),
        .level_out(sclk_s)
    );

    // serial data shares the high select pin
    csyn_sync2 u_sync_dat (
        .clk(clk),
        .arst_n(arst_n),
        .pin_in(select_high_serial_data),
        .level_out(sdat_s)
    );

    // power-down pin
    csyn_sync2 u_sync_pd (
        .clk(clk),
        .arst_n(arst_n),
        .pin_in(powerdown_pin_n),
        .level_out(pd_n_s)
    );

    // ****************************************************************
    // edge finding on the synchronised pins
    // ****************************************************************

    // the link clock is slow (hundreds of ns), so sampling is ample
    // a glitch under one clock may be missed
    assign sclk_rise = sclk_s && !st_r.clk_d;
    assign sclk_fall = !sclk_s && st_r.clk_d;
    assign pin_change = (sclk_s ^ st_r.clk_d) | (sdat_s ^ st_r.dat_d);
    // pins read low in reset, so power-down holds
    // the port locked two edges after release
    assign pd_active = !pd_n_s;

    // ****************************************************************
    // watchdog and settle timers
    // ****************************************************************

    // runs from reset, halts at expiry until a pin moves; expiry latches the pins
    // as the selection, starting the settle interval if they changed, and relocks the port
    // counts memory oscillator ticks; any pin move restarts it
    csyn_timer #(
        .LIMIT(WDOG_CYCLES),
        .START_IDLE(1'b0)
    ) u_wdog (
        .clk(clk),
        .arst_n(arst_n),
        .restart(pin_change),
        .tick(mem_vco_tick),
        .double_len(st_r.ctl[`CSYN_BIT_TO_DOUBLE]),
        .expired(wdog_expired),
        .running()
    );

    // a changed selection makes the oscillator retune
    assign new_selection = {sdat_s, sclk_s} != st_r.sel_dec;
    assign settle_restart = wdog_expired && new_selection;

    // settle interval runs on the core clock, not the oscillator
    // limitation: length ignores the doubling bit
    csyn_timer #(
        .LIMIT(SETTLE_CYCLES),
        .START_IDLE(1'b1)
    ) u_settle (
        .clk(clk),
        .arst_n(arst_n),
        .restart(settle_restart),
        .tick(1'b1),
        .double_len(1'b0),
        .expired(),
        .running(settling)
    );

    // ****************************************************************
    // serial receiver and register update
    // ****************************************************************

    // one process computes the whole next state
    always_comb begin
        st_nxt = st_r;
        // strobes last a single cycle
        st_nxt.ld_stb = 1'b0;
        st_nxt.err_stb = 1'b0;
        // pin history for edge finding
        st_nxt.clk_d = sclk_s;
        st_nxt.dat_d = sdat_s;

        // selection moves only once the pins have been quiet
        if (wdog_expired) begin
            st_nxt.sel_dec = {sdat_s, sclk_s};
        end

        // priority: power-down, expiry, then link
        if (pd_active) begin
            // no serial programming while powered down
            st_nxt.state = csyn_pkg::CSYN_LOCKED;
            st_nxt.pre_cnt = 3'h0;
            st_nxt.shreg = '0;
            st_nxt.bit_cnt = '0;
        end else if (wdog_expired) begin
            // quiet too long: relock, drop partial frame
            // silent: a stall is no coding fault
            st_nxt.state = csyn_pkg::CSYN_LOCKED;
            st_nxt.pre_cnt = 3'h0;
            st_nxt.shreg = '0;
            st_nxt.bit_cnt = '0;
        end else begin
            unique case (st_r.state)
                // hunting for the unlock preamble
                // falls mean nothing before start
                csyn_pkg::CSYN_LOCKED: begin
                    if (sclk_rise) begin
                        if (sdat_s) begin
                            // count high edges, saturating
                            if (st_r.pre_cnt != `CSYN_PREAMBLE_MIN) begin
                                st_nxt.pre_cnt = st_r.pre_cnt + 3'h1;
                            end
                        end else if (st_r.pre_cnt == `CSYN_PREAMBLE_MIN)
                        begin
                            // low edge after enough highs: start bit
                            st_nxt.state = csyn_pkg::CSYN_FALL;
                            st_nxt.pre_cnt = 3'h0;
                            st_nxt.shreg = '0;
                            st_nxt.bit_cnt = '0;
                        end else begin
                            // too few highs: begin again
                            st_nxt.pre_cnt = 3'h0;
                        end
                    end
                end
                // waiting for the complement half of a bit
                // a rise here is ignored
                csyn_pkg::CSYN_FALL: begin
                    if (sclk_fall) begin
                        st_nxt.fall_bit = sdat_s;
                        st_nxt.state = csyn_pkg::CSYN_RISE;
                    end
                end
                // waiting for the true half of a bit
                // equal halves: stop or error
                csyn_pkg::CSYN_RISE: begin
                    if (sclk_rise) begin
                        if (st_r.fall_bit != sdat_s) begin
                            if (st_r.bit_cnt == `CSYN_FRAME_BITS) begin
                                // bit past a full register: abort
                                st_nxt.err_stb = 1'b1;
                                st_nxt.state = csyn_pkg::CSYN_LOCKED;
                                st_nxt.shreg = '0;
                                st_nxt.bit_cnt = '0;
                            end else begin
                                // data then address, first bit is msb
                                st_nxt.shreg = {st_r.shreg[22:0],
                                    sdat_s};
                                st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
                                st_nxt.state = csyn_pkg::CSYN_FALL;
                            end
                        end else if (sdat_s
                            && st_r.bit_cnt == `CSYN_FRAME_BITS) begin
                            // high on both edges: load command
                            st_nxt.ld_stb = 1'b1;
                            st_nxt.ld_data = st_r.shreg[23:3];
                            st_nxt.ld_addr = st_r.shreg[2:0];
                            if (st_r.shreg[2:0] == `CSYN_ADDR_CTL) begin
                                // reserved bits stored as sent
                                st_nxt.ctl =
                                    st_r.shreg[12:3];
                            end
                            st_nxt.state = csyn_pkg::CSYN_LOCKED;
                            st_nxt.shreg = '0;
                            st_nxt.bit_cnt = '0;
                        end else begin
                            // short frame or non-complement low pair
                            st_nxt.err_stb = 1'b1;
                            st_nxt.state = csyn_pkg::CSYN_LOCKED;
                            st_nxt.shreg = '0;
                            st_nxt.bit_cnt = '0;
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************

    // single register for the whole state
    // reset loads constants only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************

    // loaded words and status straight from flops
    // address and data hold until the next load
    assign synth_control = st_r.ctl;
    assign video_sel = st_r.sel_dec;
    assign load_strobe = st_r.ld_stb;
    assign load_addr = st_r.ld_addr;
    assign load_data = st_r.ld_data;
    assign serial_error = st_r.err_stb;
    assign serial_unlocked = st_r.state != csyn_pkg::CSYN_LOCKED;

    // video clock source while the oscillator retunes
    // the mux itself sits outside this block
    assign video_fallback_active = settling;
    assign video_fallback_from_mem =
        st_r.ctl[`CSYN_BIT_FALLBACK];

    // power-down flavour chosen by the mode bit
    // both flavours low while the pin is released
    assign powerdown_mode1 =
        pd_active && !st_r.ctl[`CSYN_BIT_PD_MODE];
    assign powerdown_mode2 =
        pd_active && st_r.ctl[`CSYN_BIT_PD_MODE];

    // trim enable is the inverse of the stored bit
    // options change in the same cycle as the load strobe,
    // each a plain decode of the register
    assign duty_shorten_en = !st_r.ctl[`CSYN_BIT_DUTY];

    // one prescale choice per video register
    // msb is video register two
    assign prescale_by4 = {st_r.ctl[`CSYN_BIT_NS2],
        st_r.ctl[`CSYN_BIT_NS1], st_r.ctl[`CSYN_BIT_NS0]};

endmodule

// file: csyn_defines.svh
// constants of the synthesizer serial programming port
// assumes inclusion by bare name from every design file that needs them
`ifndef CSYN_DEFINES_SVH
`define CSYN_DEFINES_SVH

// ****************************************************************
// frame layout
// ****************************************************************
`define CSYN_FRAME_BITS 5'h18
`define CSYN_DATA_W 21
`define CSYN_ADDR_W 3
`define CSYN_PREAMBLE_MIN 3'h5
`define CSYN_ADDR_CTL 3'h6

// ****************************************************************
// control register fields and reset value
// ****************************************************************
`define CSYN_CTL_W 10
`define CSYN_CTL_RESET 10'h020
`define CSYN_BIT_PD_MODE 9
`define CSYN_BIT_FALLBACK 8
`define CSYN_BIT_TO_DOUBLE 7
`define CSYN_BIT_RSVD_B 6
`define CSYN_BIT_RSVD_A 5
`define CSYN_BIT_DUTY 4
`define CSYN_BIT_NS2 3
`define CSYN_BIT_NS1 2
`define CSYN_BIT_NS0 1

// ****************************************************************
// timing: times in microseconds, counts at the core clock rate
// ****************************************************************
`define CSYN_TMR_W 18
`define CSYN_CLK_MHZ 20
`define CSYN_WDOG_TIME_US 2000
`define CSYN_SETTLE_TIME_US 5000
`define CSYN_WDOG_CYCLES (`CSYN_WDOG_TIME_US * `CSYN_CLK_MHZ)
`define CSYN_SETTLE_CYCLES (`CSYN_SETTLE_TIME_US * `CSYN_CLK_MHZ)

`endif

// file: csyn_pkg.sv
// types shared by the synthesizer serial programming port
// assumes csyn_defines.svh is on the include path
`include "csyn_defines.svh"

package csyn_pkg;

    // serial receiver states, one-hot
    typedef enum logic [2:0] {
        CSYN_LOCKED = 3'b001,
        CSYN_FALL = 3'b010,
        CSYN_RISE = 3'b100
    } csyn_state_t;

    // whole state of the top module
    typedef struct packed {
        csyn_state_t state;
        logic [2:0] pre_cnt;
        logic [23:0] shreg;
        logic [4:0] bit_cnt;
        logic fall_bit;
        logic clk_d;
        logic dat_d;
        logic [`CSYN_CTL_W-1:0] ctl;
        logic [1:0] sel_dec;
        logic ld_stb;
        logic [`CSYN_ADDR_W-1:0] ld_addr;
        logic [`CSYN_DATA_W-1:0] ld_data;
        logic err_stb;
    } csyn_top_st_t;

    // synchroniser state
    typedef struct packed {
        logic meta;
        logic sync;
    } csyn_sync_st_t;

    // timer state
    typedef struct packed {
        logic [`CSYN_TMR_W-1:0] cnt;
        logic done;
    } csyn_tmr_st_t;

endpackage

// file: csyn_sync2.sv
// two flip-flop synchroniser for one pin level
// assumes the input is asynchronous to clk
`timescale 1ns/1ps

module csyn_sync2 (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pin_in,
    output logic level_out
);
    csyn_pkg::csyn_sync_st_t st_r; // meta and output stage
    csyn_pkg::csyn_sync_st_t st_nxt; // next value

    // meta stage feeds only the second flop
    always_comb begin
        st_nxt.meta = pin_in;
        st_nxt.sync = st_r.meta;
    end

    // registers, cleared on reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_out = st_r.sync;
endmodule

// file: csyn_timer.sv
// restartable one-shot interval timer with optional doubled length
// assumes restart and tick come from logic on clk
`timescale 1ns/1ps
`include "csyn_defines.svh"

module csyn_timer #(
    parameter logic [`CSYN_TMR_W-1:0] LIMIT = 18'h00010,
    parameter logic START_IDLE = 1'b1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic restart,
    input wire logic tick,
    input wire logic double_len,
    output logic expired,
    output logic running
);
    csyn_pkg::csyn_tmr_st_t st_r; // count and finished flag
    csyn_pkg::csyn_tmr_st_t st_nxt; // next value
    logic [`CSYN_TMR_W-1:0] limit_eff; // length in ticks
    logic fire; // last tick of the interval

    // doubling shifts the limit; width holds twice the longest default
    assign limit_eff = double_len ? {LIMIT[`CSYN_TMR_W-2:0], 1'b0} : LIMIT;
    assign fire = !st_r.done && tick && !restart
        && (st_r.cnt + 18'h00001 >= limit_eff);

    // restart wins over counting
    always_comb begin
        st_nxt = st_r;
        if (restart) begin
            st_nxt.cnt = '0;
            st_nxt.done = 1'b0;
        end else if (fire) begin
            st_nxt.done = 1'b1;
        end else if (!st_r.done && tick) begin
            st_nxt.cnt = st_r.cnt + 18'h00001;
        end
    end

    // registers; idle timers come out of reset already finished
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{cnt: '0, done: START_IDLE};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign expired = fire;
    assign running = !st_r.done;
endmodule

// file: csyn_serial_port_checker.sv
// port checker for the serial programming port
// assumes binding onto every csyn_serial_port instance
`timescale 1ns/1ps
`include "csyn_defines.svh"

module csyn_serial_port_checker #(
    parameter logic [`CSYN_TMR_W-1:0] WDOG_CYCLES = 18'h00040,
    parameter logic [`CSYN_TMR_W-1:0] SETTLE_CYCLES = 18'h00020
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [`CSYN_CTL_W-1:0] synth_control,
    input wire logic [1:0] video_sel,
    input wire logic load_strobe,
    input wire logic [`CSYN_ADDR_W-1:0] load_addr,
    input wire logic [`CSYN_DATA_W-1:0] load_data,
    input wire logic serial_error,
    input wire logic serial_unlocked,
    input wire logic video_fallback_active,
    input wire logic video_fallback_from_mem,
    input wire logic powerdown_mode1,
    input wire logic powerdown_mode2,
    input wire logic duty_shorten_en,
    input wire logic [2:0] prescale_by4
);
    // ****************************************************************
    // assertions, one core clock domain
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    strobe_pulse_a: assert property (
        load_strobe |=> !load_strobe) else $error("load strobe too long");
    error_abort_a: assert property (
        serial_error |-> !load_strobe ##1 !serial_unlocked && !serial_error)
        else $error("error did not abort and relock");
    ctl_write_a: assert property (
        load_strobe && load_addr == `CSYN_ADDR_CTL |->
        synth_control == load_data[`CSYN_CTL_W-1:0])
        else $error("control not loaded from frame");
    ctl_change_a: assert property (
        !$stable(synth_control) |-> load_strobe)
        else $error("control changed without a load");
    pd_mode_a: assert property (
        (powerdown_mode1 || powerdown_mode2) |->
        powerdown_mode2 == synth_control[`CSYN_BIT_PD_MODE] &&
        !(powerdown_mode1 && powerdown_mode2))
        else $error("power-down mode does not follow control");
    fallback_src_a: assert property (
        video_fallback_from_mem == synth_control[`CSYN_BIT_FALLBACK])
        else $error("fallback source wrong");
    duty_trim_a: assert property (
        duty_shorten_en == !synth_control[`CSYN_BIT_DUTY])
        else $error("duty trim wrong");
    prescale_sel_a: assert property (
        prescale_by4 == synth_control[`CSYN_BIT_NS2:`CSYN_BIT_NS0])
        else $error("prescale selects wrong");
    sel_hold_a: assert property (
        serial_unlocked |-> $stable(video_sel))
        else $error("selection moved during transfer");
    pd_refuse_a: assert property (
        (powerdown_mode1 || powerdown_mode2) |=> !serial_unlocked)
        else $error("unlocked during power-down");
    settle_hold_a: assert property (
        !$stable(video_sel) |=> video_fallback_active [*8])
        else $error("fallback not held while settling");
endmodule

bind csyn_serial_port csyn_serial_port_checker #(
    .WDOG_CYCLES(WDOG_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) chk_i (
    .clk(clk), .arst_n(arst_n), .synth_control(synth_control),
    .video_sel(video_sel), .load_strobe(load_strobe),
    .load_addr(load_addr), .load_data(load_data),
    .serial_error(serial_error), .serial_unlocked(serial_unlocked),
    .video_fallback_active(video_fallback_active),
    .video_fallback_from_mem(video_fallback_from_mem),
    .powerdown_mode1(powerdown_mode1), .powerdown_mode2(powerdown_mode2),
    .duty_shorten_en(duty_shorten_en), .prescale_by4(prescale_by4));

// file: csyn_host_model.sv
// host model driving the two select pins as serial clock and data
// assumes the bench calls its tasks; pins move on falling clk edges
`timescale 1ns/1ps

module csyn_host_model (
    input wire logic clk,
    output logic sck,
    output logic sda
);
    // ****************************************************************
    // pin sequencing, 400 ns link period
    // ****************************************************************
    initial begin
        sck = 1'b1; // idle high, pins also act as selects
        sda = 1'b1;
    end

    // data moves first, clock two cycles later: data set-up on both edges
    task automatic half(input logic c, input logic d);
        @(negedge clk);
        sda = d;
        repeat (2) @(negedge clk);
        sck = c;
        @(negedge clk);
    endtask

    // five high rises then the low start rise
    task automatic pre();
        repeat (5) begin
            half(1'b0, 1'b1);
            half(1'b1, 1'b1);
        end
        half(1'b0, 1'b0);
        half(1'b1, 1'b0);
    endtask

    // complement on the fall, true value on the rise
    task automatic sbit(input logic b);
        half(1'b0, ~b);
        half(1'b1, b);
    endtask

    // load command: data high, clock falls then rises
    task automatic stop();
        half(1'b0, 1'b1);
        half(1'b1, 1'b1);
    endtask

    // whole frame, first bit sent is w[n-1]
    task automatic xfer(input logic [24:0] w, input int n);
        pre();
        for (int i = n - 1; i >= 0; i--) begin
            sbit(w[i]);
        end
        stop();
    endtask
endmodule

// file: csyn_serial_port_tb.sv
// self-checking bench for the serial programming port
// assumes the host model and the bound checker
`timescale 1ns/1ps
`include "csyn_defines.svh"

module csyn_serial_port_tb;
    // ****************************************************************
    // clock, pins, counters
    // ****************************************************************
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic pd_n = 1'b1; // power-down pin, idle released
    logic sck;
    logic sda;
    logic [`CSYN_CTL_W-1:0] ctl;
    logic [1:0] vsel;
    logic ls;
    logic [`CSYN_ADDR_W-1:0] la;
    logic [`CSYN_DATA_W-1:0] ld;
    logic se;
    logic su;
    logic fa;
    logic fm;
    logic m1;
    logic m2;
    logic du;
    logic [2:0] pr;
    int bad_count = 0;
    int comparisons = 0;
    int n_load = 0;
    int n_err = 0;
    int n_fb = 0;
    logic [31:0] rs = 32'h00005F6D; // xorshift state
    logic [9:0] exp_ctl = 10'h020; // model of the control register
    logic [20:0] d;
    logic [24:0] w;

    always #25 clk = ~clk;

    csyn_host_model csyn_host_model_i (.clk(clk), .sck(sck), .sda(sda));

    // short counts keep the run brief
    csyn_serial_port #(.WDOG_CYCLES(18'h00040), .SETTLE_CYCLES(18'h00020))
    csyn_serial_port_i (.clk(clk), .arst_n(arst_n),
        .select_low_serial_clock(sck), .select_high_serial_data(sda),
        .powerdown_pin_n(pd_n), .mem_vco_tick(1'b1), .synth_control(ctl),
        .video_sel(vsel), .load_strobe(ls), .load_addr(la), .load_data(ld),
        .serial_error(se), .serial_unlocked(su), .video_fallback_active(fa),
        .video_fallback_from_mem(fm), .powerdown_mode1(m1),
        .powerdown_mode2(m2), .duty_shorten_en(du), .prescale_by4(pr));

    // pulse and level counters
    always @(posedge clk) begin
        if (ls === 1'b1) n_load++;
        if (se === 1'b1) n_err++;
        if (fa === 1'b1) n_fb++;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // one frame, then the pulse counts it should have caused
    task automatic frame(input logic [24:0] f, input int n,
                         input int el, input int ee);
        int l0;
        int e0;
        l0 = n_load;
        e0 = n_err;
        csyn_host_model_i.xfer(f, n);
        repeat (20) @(negedge clk);
        check("loads", n_load - l0, el);
        check("errors", n_err - e0, ee);
        repeat (300) @(negedge clk); // outlast even a doubled watchdog
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        check("ctl reset", ctl, `CSYN_CTL_RESET);
        for (int k = 0; k < 10; k++) begin
            rs = xs(rs);
            d = rs[20:0];
            d[6:5] = 2'h0; // reserved bits written as zero
            d[9] = k[0];
            w = {1'b0, d, (k < 8) ? k[2:0] : 3'h6};
            frame(w, 24, 1, 0);
            check("addr", la, w[2:0]);
            check("data", ld, d);
            if (w[2:0] == 3'h6) exp_ctl = d[9:0];
            check("ctl", ctl, exp_ctl);
            check("fallback", fm, exp_ctl[`CSYN_BIT_FALLBACK]);
            check("duty", du, !exp_ctl[`CSYN_BIT_DUTY]);
            check("prescale", pr, exp_ctl[3:1]);
            if (w[2:0] == 3'h6) begin
                pd_n = 1'b0;
                repeat (10) @(negedge clk);
                check("mode1", m1, !exp_ctl[9]);
                check("mode2", m2, exp_ctl[9]);
                frame(w, 24, 0, 0);
                pd_n = 1'b1;
            end
        end
        frame({1'b0, w[24:1]}, 23, 0, 1);
        frame({1'b1, w[23:0]}, 25, 0, 1);
        // stalled transfer: watchdog relocks, later stop is no load
        n_load = 0;
        csyn_host_model_i.pre();
        repeat (5) csyn_host_model_i.sbit(1'b1);
        check("unlocked", su, 1'b1);
        repeat (300) @(negedge clk);
        check("relocked", su, 1'b0);
        csyn_host_model_i.stop();
        repeat (20) @(negedge clk);
        check("no load", n_load, 0);
        n_fb = 0;
        csyn_host_model_i.half(1'b1, 1'b0); // select {high,low} = 01
        repeat (400) @(negedge clk);
        check("video sel", vsel, 2'h1);
        check("settle", n_fb, 32);
        end_of_test();
    end

    // ****************************************************************
    // watchdog, about four times the expected run
    // ****************************************************************
    initial begin
        #2000000;
        bad_count++;
        end_of_test();
    end
endmodule
